// File: src/input_capture_with_timer.sv
// Input capture unit with dedicated 16-bit counter and 4-entry FIFO
//
// Operation
// R1: Free-running counter wraps FFFFh to 0000h
// R2: Capture event pushes 16-bit counter value
// R3: FIFO keeps up to four captures
// R4: Sync mode: sync event clears counter
// R5: Trigger mode: counter held until sync event
// R6: Zero source free-run; nonzero sync or trigger
// R7: Zero source with trigger: software trigger
// R8: Odd low half, even high, wrap increments
// R9: Cascade only when both units enable it
// R10: Even unit follows odd unit in step
// R11: Cascaded sync held reset until source enabled
// R12: Not-empty flag tracks unread captures
// R13: Read-only overflow flag
// R14: Interrupt every first to fourth capture
// R15: Mode field selects edge and prescale
// R16: Both-edges mode interrupts on every capture
// R17: Mode 111 rising-edge wake interrupt only
// R18: Timebase select chooses counter clock
// R19: Idle-stop halts unit in Idle
// R20: Trigger status set by hardware or software
// R21: Software drains FIFO before configuring
// R22: Software programs even unit first
// R23: Sync source zero means none
// R24: Capture into full FIFO sets overflow
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`include "input_capture_cfg.svh"

module input_capture_with_timer
    import input_capture_pkg::*;
#(
    parameter bit IS_HIGH_HALF = 1'b0,
    parameter int FIFO_DEPTH   = 4
)(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        capture_input,
    input  wire logic [4:0]  timer_tick,
    input  wire logic [31:0] sync_events,
    input  wire logic [31:0] sync_enabled,
    input  wire logic        idle_mode,
    input  wire logic        sleep_mode,
    input  wire logic        partner_cascade,
    input  wire logic        partner_wrap,
    input  wire logic        partner_clear,
    input  wire logic        partner_capture,
    output logic             cascade_out,
    output logic             wrap_out,
    output logic             clear_out,
    output logic             capture_out,
    output logic             capture_irq
);

    localparam int PW = $clog2(FIFO_DEPTH);

    logic [13:0]   con1;
    logic [8:0]    con2;
    logic          trigger_status;
    logic          capture_overflow;
    logic [15:0]   capture_counter;
    logic [15:0]   fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   fill;
    logic          input_prev;
    logic [3:0]    prescale_cnt;
    logic [1:0]    irq_cnt;
    logic          served;
    logic          pop_ok;

    logic          idle_stop;
    logic [2:0]    timebase_select;
    logic [1:0]    captures_per_interrupt;
    logic [2:0]    capture_mode;
    logic          cascade_enable;
    logic          trigger_select;
    logic [4:0]    sync_source_select;

    assign idle_stop              = con1[`CON1_IDLE_STOP_BIT];
    assign timebase_select        = con1[`CON1_TBSEL_LSB +: 3];
    assign captures_per_interrupt = con1[`CON1_CPI_LSB +: 2];
    assign capture_mode           = con1[`CON1_MODE_LSB +: 3];
    assign cascade_enable         = con2[`CON2_CASCADE_BIT];
    assign trigger_select         = con2[`CON2_TRIG_SEL_BIT];
    assign sync_source_select     = con2[`CON2_SYNC_LSB +: 5];

    // Bus handshake
    logic bus_req;
    logic bus_commit;
    logic wr_con1;
    logic wr_con2;
    logic fifo_pop;

    assign bus_req    = avs_read | avs_write;
    assign bus_commit = bus_req & ~avs_waitrequest;
    assign wr_con1    = bus_commit & avs_write
                        & (avs_address == `CAP_OFS_CONTROL_ONE);
    assign wr_con2    = bus_commit & avs_write
                        & (avs_address == `CAP_OFS_CONTROL_TWO);

    // Mode decode
    run_mode_t run_mode;
    logic      cascade_active;
    logic      follower;
    logic      sync_hit;
    logic      unit_off;
    logic      halted;
    logic      tick;

    always_comb
    begin
        if (sync_source_select == `SYNC_NONE)                 // R23
            run_mode = trigger_select ? RUN_SOFT : RUN_FREE;  // R6 R7
        else
            run_mode = trigger_select ? RUN_TRIGGER : RUN_SYNC; // R6
    end

    assign cascade_active = cascade_enable & partner_cascade; // R9
    assign follower       = IS_HIGH_HALF & cascade_active;   // R8 R10
    assign sync_hit       = (sync_source_select != `SYNC_NONE)
                            & sync_events[sync_source_select];
    assign unit_off       = (capture_mode == `MODE_OFF)
                            | (capture_mode == `MODE_UNUSED)
                            | (capture_mode == `MODE_WAKE_PIN); // R15 R17
    assign halted         = idle_mode & idle_stop;           // R19

    always_comb
    begin
        case (timebase_select)                               // R18
            `TB_SYSTEM_CLOCK: tick = 1'b1;
            `TB_TIMER_ONE:    tick = timer_tick[0];
            `TB_TIMER_TWO:    tick = timer_tick[1];
            `TB_TIMER_THREE:  tick = timer_tick[2];
            `TB_TIMER_FOUR:   tick = timer_tick[3];
            `TB_TIMER_FIVE:   tick = timer_tick[4];
            default:          tick = 1'b0;
        endcase
    end

    // Counter control
    logic triggered_mode;
    logic counter_clear;
    logic counter_adv;
    logic counter_wrap;

    assign triggered_mode = (run_mode == RUN_TRIGGER)
                            | (run_mode == RUN_SOFT);

    always_comb
    begin
        if (follower)
        begin
            counter_clear = partner_clear;                   // R10
            counter_adv   = partner_wrap & ~halted;          // R8
        end
        else
        begin
            counter_clear = unit_off
                | (triggered_mode & ~trigger_status)         // R5 R20
                | ((run_mode == RUN_SYNC) & sync_hit)        // R4
                | (cascade_active & (run_mode == RUN_SYNC)
                   & ~sync_enabled[sync_source_select]);     // R11
            counter_adv   = tick & ~halted;
        end
    end

    assign counter_wrap = ~follower & ~counter_clear & counter_adv
                          & (capture_counter == `COUNTER_MAX);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            capture_counter <= 16'h0000;
        else if (counter_clear)
            capture_counter <= 16'h0000;
        else if (counter_adv)
            capture_counter <= capture_counter + 16'h0001;   // R1
    end

    // Edge detection and capture qualification
    logic rise;
    logic fall;
    logic capture_evt;
    logic can_capture;

    assign rise        = capture_input & ~input_prev;
    assign fall        = ~capture_input & input_prev;
    assign can_capture = ~unit_off & ~halted
                         & ~(triggered_mode & ~trigger_status); // R7

    always_comb
    begin
        if (follower)
            capture_evt = partner_capture & ~halted;         // R8
        else if (!can_capture)
            capture_evt = 1'b0;
        else
        begin
            case (capture_mode)                              // R15
                `MODE_BOTH_EDGES: capture_evt = rise | fall;
                `MODE_FALLING:    capture_evt = fall;
                `MODE_RISING:     capture_evt = rise;
                `MODE_RISE_DIV4:
                    capture_evt = rise
                        & (prescale_cnt[1:0] == 2'(`PRESCALE_DIV4_LAST));
                `MODE_RISE_DIV16:
                    capture_evt = rise
                        & (prescale_cnt == `PRESCALE_DIV16_LAST);
                default:          capture_evt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            input_prev <= 1'b0;
        else
            input_prev <= capture_input;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            prescale_cnt <= 4'h0;
        else if (!can_capture || capture_mode == `MODE_RISING)
            prescale_cnt <= 4'h0;
        else if (rise)
            prescale_cnt <= prescale_cnt + 4'h1;             // R15
    end

    // Capture FIFO
    logic fifo_full;
    logic fifo_empty;
    logic push;

    assign fifo_full  = (fill == (PW+1)'(FIFO_DEPTH));
    assign fifo_empty = (fill == '0);
    assign push       = capture_evt & ~fifo_full;            // R24
    assign fifo_pop   = bus_commit & avs_read & pop_ok
                        & (avs_address == `CAP_OFS_FIFO_READ);

    always_ff @(posedge sys_clk)
    begin
        if (push)
            fifo_mem[wr_ptr] <= capture_counter;             // R2
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + PW'(1);
            if (fifo_pop)
                rd_ptr <= rd_ptr + PW'(1);
            if (push && !fifo_pop)
                fill <= fill + (PW+1)'(1);                   // R3
            else if (fifo_pop && !push)
                fill <= fill - (PW+1)'(1);                   // R12
        end
    end

    // Overflow flag, set wins over the clear by mode off
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            capture_overflow <= 1'b0;
        else if (capture_evt && fifo_full)
            capture_overflow <= 1'b1;                        // R13 R24
        else if (wr_con1
                 && avs_writedata[`CON1_MODE_LSB +: 3] == `MODE_OFF)
            capture_overflow <= 1'b0;
    end

    // Control registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            con1 <= 14'(`CON1_RESET);
        else if (wr_con1)
        begin
            con1[`CON1_IDLE_STOP_BIT] <= avs_writedata[`CON1_IDLE_STOP_BIT];
            con1[`CON1_TBSEL_LSB +: 3] <= avs_writedata[`CON1_TBSEL_LSB +: 3];
            con1[`CON1_CPI_LSB +: 2]  <= avs_writedata[`CON1_CPI_LSB +: 2];
            con1[`CON1_MODE_LSB +: 3] <= avs_writedata[`CON1_MODE_LSB +: 3];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            con2 <= 9'(`CON2_RESET);
        else if (wr_con2)
        begin
            con2[`CON2_CASCADE_BIT]   <= avs_writedata[`CON2_CASCADE_BIT];
            con2[`CON2_TRIG_SEL_BIT]  <= avs_writedata[`CON2_TRIG_SEL_BIT];
            con2[`CON2_SYNC_LSB +: 5] <= avs_writedata[`CON2_SYNC_LSB +: 5];
        end
    end

    // Trigger status: hardware set wins over a software clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            trigger_status <= 1'b0;
        else if (run_mode == RUN_TRIGGER && sync_hit)
            trigger_status <= 1'b1;                          // R5 R20
        else if (wr_con2)
            trigger_status <= avs_writedata[`CON2_TRIG_STAT_BIT]; // R7 R20
    end

    // Interrupt generation
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_cnt     <= 2'h0;
            capture_irq <= 1'b0;
        end
        else if (capture_mode == `MODE_WAKE_PIN)
        begin
            irq_cnt     <= 2'h0;
            capture_irq <= rise & (sleep_mode | idle_mode);  // R17
        end
        else if (capture_evt && capture_mode == `MODE_BOTH_EDGES)
        begin
            irq_cnt     <= 2'h0;
            capture_irq <= 1'b1;                             // R16
        end
        else if (capture_evt)
        begin
            capture_irq <= (irq_cnt == captures_per_interrupt); // R14
            irq_cnt     <= (irq_cnt == captures_per_interrupt)
                           ? 2'h0 : irq_cnt + 2'h1;
        end
        else
        begin
            if (unit_off)
                irq_cnt <= 2'h0;
            capture_irq <= 1'b0;
        end
    end

    // Cascade strobes toward the even unit, one cycle behind
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wrap_out    <= 1'b0;
            clear_out   <= 1'b0;
            capture_out <= 1'b0;
            cascade_out <= 1'b0;
        end
        else
        begin
            wrap_out    <= counter_wrap;                     // R8
            clear_out   <= ~follower & counter_clear;        // R10 R11
            capture_out <= ~follower & push;
            cascade_out <= cascade_enable;                   // R9
        end
    end

    // Avalon slave: one wait cycle, effects at the edge waitrequest is low
    logic [31:0] next_readdata;

    always_comb
    begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            `CAP_OFS_CONTROL_ONE:
            begin
                next_readdata[13:0] = con1;
                next_readdata[`CON1_OVERFLOW_BIT]  = capture_overflow;
                next_readdata[`CON1_NOT_EMPTY_BIT] = ~fifo_empty; // R12
            end
            `CAP_OFS_CONTROL_TWO:
            begin
                next_readdata[8:0] = con2;
                next_readdata[`CON2_TRIG_STAT_BIT] = trigger_status;
            end
            `CAP_OFS_FIFO_READ:
                next_readdata[15:0] = fifo_empty ? 16'h0000
                                                 : fifo_mem[rd_ptr];
            `CAP_OFS_COUNTER:
                next_readdata[15:0] = capture_counter;
            default:
                next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            served          <= 1'b0;
            pop_ok          <= 1'b0;
        end
        else if (bus_req && avs_waitrequest && !served)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
            served          <= 1'b1;
            pop_ok          <= ~fifo_empty;
        end
        else
        begin
            avs_waitrequest <= 1'b1;
            served          <= 1'b0;
        end
    end

    // Checks
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_wrap_to_zero: assert property ( // R1
        counter_wrap |=> capture_counter == 16'h0000 && wrap_out)
        else $error("counter did not wrap to zero");

    a_push_stores_value: assert property ( // R2
        push |=> fifo_mem[$past(wr_ptr)] == $past(capture_counter))
        else $error("captured value not stored");

    a_fifo_depth: assert property ( // R3
        fill <= (PW+1)'(FIFO_DEPTH))
        else $error("fifo fill beyond depth");

    a_sync_clears: assert property ( // R4
        !follower && run_mode == RUN_SYNC && sync_hit
        |=> capture_counter == 16'h0000)
        else $error("sync event did not clear counter");

    a_trigger_hold: assert property ( // R5
        !follower && triggered_mode && !trigger_status && !wr_con2
        |=> capture_counter == 16'h0000 ##1 capture_counter == 16'h0000
            || trigger_status)
        else $error("counter ran before trigger");

    a_hw_trigger_set: assert property ( // R20
        run_mode == RUN_TRIGGER && sync_hit |=> trigger_status)
        else $error("trigger status not set by hardware");

    a_overflow_full: assert property ( // R24
        capture_evt && fifo_full |=> capture_overflow && fill <= $past(fill))
        else $error("overflow not flagged or fill changed");

    a_both_edge_irq: assert property ( // R16
        capture_evt && capture_mode == `MODE_BOTH_EDGES |=> capture_irq)
        else $error("both-edge capture gave no interrupt");

    a_idle_halts: assert property ( // R19
        halted && !counter_clear |=> $stable(capture_counter))
        else $error("counter moved while halted in idle");

    a_bus_answer: assert property (
        bus_req && avs_waitrequest && !served |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");

    c_overflow: cover property (capture_evt && fifo_full);
    c_wrap: cover property (counter_wrap);
    c_fourth_irq: cover property (
        capture_irq && captures_per_interrupt == 2'h3);
    c_soft_trigger: cover property (
        run_mode == RUN_SOFT && wr_con2 && !trigger_status);

endmodule

// File: src/input_capture_cfg.svh
// Register map, field positions, reset values and codes of the capture unit
`ifndef INPUT_CAPTURE_CFG_SVH
`define INPUT_CAPTURE_CFG_SVH

// Byte offsets of the 32-bit register words
`define CAP_OFS_CONTROL_ONE   4'h0
`define CAP_OFS_CONTROL_TWO   4'h4
`define CAP_OFS_FIFO_READ     4'h8
`define CAP_OFS_COUNTER       4'hC

// capture_control_one fields
`define CON1_IDLE_STOP_BIT    13
`define CON1_TBSEL_LSB        10
`define CON1_CPI_LSB          5
`define CON1_OVERFLOW_BIT     4
`define CON1_NOT_EMPTY_BIT    3
`define CON1_MODE_LSB         0
`define CON1_RESET            16'h0000

// capture_control_two fields
`define CON2_CASCADE_BIT      8
`define CON2_TRIG_SEL_BIT     7
`define CON2_TRIG_STAT_BIT    6
`define CON2_SYNC_LSB         0
`define CON2_RESET            16'h000D

// Capture mode codes
`define MODE_OFF              3'h0
`define MODE_BOTH_EDGES       3'h1
`define MODE_FALLING          3'h2
`define MODE_RISING           3'h3
`define MODE_RISE_DIV4        3'h4
`define MODE_RISE_DIV16       3'h5
`define MODE_UNUSED           3'h6
`define MODE_WAKE_PIN         3'h7

// Timebase select codes
`define TB_TIMER_THREE        3'h0
`define TB_TIMER_TWO          3'h1
`define TB_TIMER_FOUR         3'h2
`define TB_TIMER_FIVE         3'h3
`define TB_TIMER_ONE          3'h4
`define TB_SYSTEM_CLOCK       3'h7

// Prescaler terminal counts
`define PRESCALE_DIV4_LAST    4'h3
`define PRESCALE_DIV16_LAST   4'hF

`define COUNTER_MAX           16'hFFFF
`define SYNC_NONE             5'h00

`endif

// File: src/input_capture_pkg.sv
// Types shared by the capture unit
package input_capture_pkg;

    typedef enum logic [3:0] {
        RUN_FREE    = 4'b0001,
        RUN_SYNC    = 4'b0010,
        RUN_TRIGGER = 4'b0100,
        RUN_SOFT    = 4'b1000
    } run_mode_t;

endpackage

// File: testbench/pulse_source.sv
// Model of the capture pin and the timer tick sources
`timescale 1ns/100ps

module pulse_source (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [9:0] total,
    input  wire logic       tick_run,
    output logic            pin,
    output logic [4:0]      tick,
    output logic            busy
);
    logic [9:0] left;
    logic [1:0] hold;

    assign busy = (left != 10'h000);

    // Each pin level lasts one to four cycles
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin  <= 1'b0;
            left <= 10'h000;
            hold <= 2'h0;
        end
        else if (start)
            left <= total;
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
        else if (busy)
        begin
            pin  <= ~pin;
            left <= left - {9'h000, pin};
            hold <= 2'($urandom);
        end
    end

    // Timer ticks arrive at random while enabled
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tick <= 5'h00;
        else
            tick <= tick_run ? 5'($urandom) : 5'h00;
    end
endmodule

// File: testbench/input_capture_with_timer_test.sv
// Self-checking bench for the input capture unit
`timescale 1ns/100ps

module input_capture_with_timer_test;
    logic        sys_clk;
    logic        rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        capture_input;
    logic [4:0]  timer_tick;
    logic [31:0] sync_events;
    logic        idle_mode;
    logic        sleep_mode;
    logic        capture_irq;
    logic        start;
    logic [9:0]  total;
    logic        tick_run;
    logic        busy;
    logic        pin_d;
    logic [31:0] q;
    logic [31:0] a;
    logic [31:0] sync_on = '1;
    logic        cas;
    int          mismatches;
    int          check_count;
    int          irq_seen;
    int          tick_hits;
    int          sel;
    int          cycles;
    int          cpi;
    int          stamp[$];
    int          tick_map[7] = '{2, 1, 3, 4, 0, 5, 5};

    input_capture_with_timer i_dut (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .capture_input(capture_input),
        .timer_tick(timer_tick), .sync_events(sync_events),
        .sync_enabled(sync_on), .idle_mode(idle_mode),
        .sleep_mode(sleep_mode), .partner_cascade(cas),
        .partner_wrap(1'b0), .partner_clear(1'b0),
        .partner_capture(1'b0), .cascade_out(cas), .wrap_out(),
        .clear_out(), .capture_out(), .capture_irq(capture_irq));

    pulse_source i_src (
        .sys_clk(sys_clk), .rst(rst), .start(start), .total(total),
        .tick_run(tick_run), .pin(capture_input), .tick(timer_tick),
        .busy(busy));

    always #5 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (capture_input === 1'b1 && pin_d === 1'b0)
            stamp.push_back(cycles);
        pin_d = capture_input;
        if (capture_irq === 1'b1)
            irq_seen++;
        if (sel < 5 && timer_tick[sel] === 1'b1)
            tick_hits++;
        if (cycles > 90000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_range(input string what, input int lo,
                             input int hi, input logic [31:0] got);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            mismatches++;
            $display("mismatch %s expected %0d..%0d seen %h",
                     what, lo, hi, got);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] ad,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= ad;
        avs_writedata <= {16'h0000, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40)
            mismatches++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    function automatic logic [15:0] con1(logic s, logic [2:0] t,
                                         logic [1:0] c, logic [2:0] m);
        return {2'h0, s, t, 3'h0, c, 2'h0, m};
    endfunction

    function automatic logic [15:0] con2(logic tr, logic st,
                                         logic [4:0] sy);
        return {8'h00, tr, st, 1'b0, sy};
    endfunction

    function automatic int exp_irq(int m, int c, int n);
        case (m)
            1: return 2 * n;
            2, 3: return n / (c + 1);
            4: return n / 4 / (c + 1);
            5: return n / 16 / (c + 1);
            7: return n;
            default: return 0;
        endcase
    endfunction

    task automatic pulses(input logic [9:0] n);
        total <= n;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        for (int i = 0; i < 6000 && (busy || i < 2); i++)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
    endtask

    initial
    begin
        sys_clk = 0; rst = 1; avs_address = 0; avs_read = 0;
        avs_write = 0; avs_writedata = 0; sync_events = 0;
        idle_mode = 0; sleep_mode = 0; start = 0; total = 0;
        tick_run = 0; pin_d = 0; sel = 5; cycles = 0;
        mismatches = 0; check_count = 0; irq_seen = 0; tick_hits = 0;
        void'($urandom(32'h3a22_55e9));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        bus(0, 4'h0, 0); chk("control_one", 32'h0000_0000, q);
        bus(0, 4'h4, 0); chk("control_two", 32'h0000_000D, q);
        bus(1, 4'h2, 16'hFFFF);
        bus(0, 4'h2, 0); chk("unmapped", 32'h0000_0000, q);
        bus(1, 4'h4, con2(0, 0, 5'h00));
        for (int m = 0; m < 8; m++)
        begin
            cpi = $urandom % 4;
            sleep_mode <= (m == 7);
            bus(1, 4'h0, con1(0, 3'h7, cpi[1:0], m[2:0]));
            irq_seen = 0;
            pulses(10'h0C0);
            chk("irq count", exp_irq(m, cpi, 192), irq_seen);
        end
        sleep_mode <= 1'b0;
        bus(1, 4'h0, con1(0, 3'h7, 2'h0, 3'h3));
        for (int i = 0; i < 8; i++)
        begin
            bus(0, 4'h0, 0);
            if (q[3] !== 1'b1)
                break;
            bus(0, 4'h8, 0);
        end
        bus(0, 4'hC, 0); a = q; bus(0, 4'hC, 0);
        chk("counter step", {16'h0000, a[15:0] + 16'h0003}, q);
        bus(0, 4'hC, 0); a = q;
        repeat (65533) @(posedge sys_clk);
        bus(0, 4'hC, 0); chk("counter wrap", a, q);
        stamp.delete();
        pulses(10'h005);
        bus(0, 4'h0, 0); chk("flags full", 32'h0000_1C1B, q);
        for (int i = 0; i < 4; i++)
        begin
            bus(0, 4'h8, 0);
            if (i == 0)
                a = q;
            chk("fifo value", {16'h0000,
                a[15:0] + 16'(stamp[i] - stamp[0])}, q);
        end
        bus(0, 4'h0, 0); chk("flags drained", 32'h0000_1C13, q);
        bus(0, 4'h8, 0); chk("empty read", 32'h0000_0000, q);
        bus(1, 4'h0, con1(0, 3'h7, 2'h0, 3'h0) | 16'h0018);
        bus(0, 4'h0, 0); chk("read only", 32'h0000_1C00, q);
        idle_mode <= 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            bus(1, 4'h0, con1(s[0], 3'h7, 2'h0, 3'h3));
            bus(0, 4'hC, 0); a = q; bus(0, 4'hC, 0);
            chk("idle", {16'h0000, a[15:0] + (s[0] ? 16'h0 : 16'h3)}, q);
        end
        idle_mode <= 1'b0;
        for (int t = 0; t < 7; t++)
        begin
            bus(1, 4'h0, con1(0, t[2:0], 2'h0, 3'h3));
            bus(0, 4'hC, 0); a = q;
            sel = tick_map[t]; tick_hits = 0; tick_run <= 1'b1;
            repeat (20) @(posedge sys_clk);
            tick_run <= 1'b0;
            repeat (4) @(posedge sys_clk);
            bus(0, 4'hC, 0);
            chk("timebase", {16'h0000, a[15:0] + 16'(tick_hits)}, q);
        end
        sel = 5;
        bus(1, 4'h0, con1(0, 3'h7, 2'h0, 3'h3));
        bus(1, 4'h4, con2(1, 0, 5'h01));
        sync_events <= 32'h0000_0004;
        @(posedge sys_clk); sync_events <= 32'h0000_0000;
        bus(0, 4'hC, 0); chk("trigger held", 32'h0000_0000, q);
        sync_events <= 32'h0000_0002;
        @(posedge sys_clk); sync_events <= 32'h0000_0000;
        bus(0, 4'h4, 0); chk("trigger flag", con2(1, 1, 5'h01), q);
        bus(0, 4'hC, 0); chk_range("trigger run", 1, 16, q);
        bus(1, 4'h4, con2(1, 0, 5'h00));
        bus(0, 4'hC, 0); chk("soft held", 32'h0000_0000, q);
        bus(1, 4'h4, con2(1, 1, 5'h00));
        bus(0, 4'hC, 0); chk_range("soft run", 1, 16, q);
        bus(1, 4'h4, con2(0, 0, 5'h01));
        repeat (40) @(posedge sys_clk);
        sync_events <= 32'h0000_0002;
        @(posedge sys_clk); sync_events <= 32'h0000_0000;
        bus(0, 4'hC, 0); chk_range("sync clear", 0, 8, q);
        sync_on <= '0;
        bus(1, 4'h4, con2(0, 0, 5'h01) | 16'h0100);
        repeat (2) @(posedge sys_clk);
        bus(0, 4'hC, 0); chk("cascade hold", 32'h0000_0000, q);
        sync_on <= '1;
        bus(0, 4'hC, 0); chk_range("cascade run", 1, 16, q);
        give_verdict();
    end
endmodule
